// >>> core/dpm_pkg.sv
// Package for the dual-port memory port controller: widths, timing, types
`default_nettype none
package dpm_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  // Mailbox words: left-port flag word and right-port flag word
  localparam logic [ADDR_W-1:0] LEFT_MAILBOX_ADDR = 10'h3FE;
  localparam logic [ADDR_W-1:0] RIGHT_MAILBOX_ADDR = 10'h3FF;
  // Timing in ns, slowest speed grade, and clock period
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_PULSE_NS = 40;
  localparam int OUT_OFF_NS = 30;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 20;
  localparam int WRITE_HOLD_AFTER_STALL_NS = 40;
  localparam int READ_ACCESS_NS = 55;
  localparam int STALL_RELEASE_TO_DATA_NS = 45;
  // Least times round up to whole cycles
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_OFF_CYC =
    (OUT_OFF_NS + DATA_SETUP_TO_WRITE_END_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int WRITE_HOLD_CYC =
    (WRITE_HOLD_AFTER_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_DATA_CYC =
    (STALL_RELEASE_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC_A =
    (WRITE_PULSE_CYC > TURN_OFF_CYC) ? WRITE_PULSE_CYC : TURN_OFF_CYC;
  localparam int WR_CYC =
    (WR_CYC_A > WRITE_HOLD_CYC) ? WR_CYC_A : WRITE_HOLD_CYC;
  localparam int RD_CYC =
    (READ_ACCESS_CYC > STALL_DATA_CYC) ? READ_ACCESS_CYC : STALL_DATA_CYC;
  // Reset values of the pin drive
  localparam logic PIN_IDLE = 1'b1;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpm_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic select_n;
    logic write_n;
    logic out_en_n;
  } dpm_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_RELEASE = 3'h2,
    ST_DONE = 3'h6
  } dpm_state_t;
endpackage
`default_nettype wire

// >>> core/dpm_port_ctrl.sv
// Controller driving one port of an asynchronous two-port memory
`default_nettype none
module dpm_port_ctrl
  import dpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User request and answer
  input wire logic req_valid,
  output logic req_ready,
  input wire dpm_req_t req,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic was_stalled,
  output logic mailbox_pending,
  // Memory port pins
  output dpm_pins_t pins,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic stall_n,
  input wire logic mailbox_flag_n
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [DATA_W+1:0] sync1_reg;
  logic [DATA_W+1:0] sync2_reg;
  logic stall_s;
  logic flag_s;
  logic [DATA_W-1:0] data_s;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= {(DATA_W+2){1'b1}};
      sync2_reg <= {(DATA_W+2){1'b1}};
    end
    else
    begin
      sync1_reg <= {stall_n, mailbox_flag_n, data_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign stall_s = sync2_reg[DATA_W+1];
  assign flag_s = sync2_reg[DATA_W];
  assign data_s = sync2_reg[DATA_W-1:0];

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  dpm_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  dpm_pins_t pins_reg, pins_next;
  logic write_reg, write_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic oe_reg, oe_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic stalled_reg, stalled_next;
  logic flag_reg, flag_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pins_next = pins_reg;
    write_next = write_reg;
    wdata_next = wdata_reg;
    oe_next = oe_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    stalled_next = stalled_reg;
    flag_next = !flag_s;
    case (state_reg)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          // address loaded while select and strobe high
          pins_next.addr = req.addr;
          pins_next.select_n = 1'b0;
          // outputs stay off for writes, so data may be driven
          pins_next.out_en_n = req.write;
          write_next = req.write;
          wdata_next = req.wdata;
          oe_next = req.write;
          stalled_next = 1'b0;
          cnt_next = '0;
          state_next = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // select already low before strobe, data set up first
        pins_next.write_n = !write_reg;
        state_next = ST_STROBE;
      end
      ST_STROBE:
      begin
        // a stalled access restarts its timing once released
        if (!stall_s)
        begin
          stalled_next = 1'b1;
          cnt_next = '0;
        end
        else if (write_reg && cnt_reg >= CNT_W'(WR_CYC - 1))
        begin
          // strobe held past stall release; pulse width
          pins_next.write_n = 1'b1;
          pins_next.select_n = 1'b1;
          state_next = ST_RELEASE;
        end
        else if (!write_reg && cnt_reg >= CNT_W'(RD_CYC - 1))
        begin
          rdata_next = data_s;
          pins_next.out_en_n = 1'b1;
          pins_next.select_n = 1'b1;
          state_next = ST_RELEASE;
        end
        else
        begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      ST_RELEASE:
      begin
        // Data held one cycle past strobe rise for hold time
        oe_next = 1'b0;
        done_next = 1'b1;
        state_next = ST_DONE;
      end
      ST_DONE:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      pins_reg <= '{addr: '0, select_n: PIN_IDLE, write_n: PIN_IDLE,
                    out_en_n: PIN_IDLE};
      write_reg <= 1'b0;
      wdata_reg <= '0;
      oe_reg <= 1'b0;
      rdata_reg <= '0;
      done_reg <= 1'b0;
      stalled_reg <= 1'b0;
      flag_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pins_reg <= pins_next;
      write_reg <= write_next;
      wdata_reg <= wdata_next;
      oe_reg <= oe_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      stalled_reg <= stalled_next;
      flag_reg <= flag_next;
    end
  end

  // Stall is seen two cycles late; the device itself gates the strobe
  assign req_ready = (state_reg == ST_IDLE);
  assign pins = pins_reg;
  assign data_out = wdata_reg;
  assign data_oe = oe_reg;
  assign rdata = rdata_reg;
  assign done = done_reg;
  assign was_stalled = stalled_reg;
  assign mailbox_pending = flag_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;

  always_comb
  begin
    low_cnt_next = '0;
    if (!pins_reg.write_n && stall_s)
    begin
      low_cnt_next = low_cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_cnt_reg <= '0;
    else
      low_cnt_reg <= low_cnt_next;
  end

  sequence s_access_close;
    ##1 done_reg ##1 req_ready;
  endsequence

  a_addr_change_idle: assert property (
    @(posedge clk) disable iff (rst)
    $changed(pins_reg.addr) |-> $past(pins_reg.select_n)
      && $past(pins_reg.write_n))
    else $error("address moved during an active access");

  a_no_data_clash: assert property (@(posedge clk) disable iff (rst)
    oe_reg |-> pins_reg.out_en_n)
    else $error("data driven while port outputs enabled");

  // Seen with the rise, the count already holds the low time since the last stall
  a_pulse_width: assert property (@(posedge clk) disable iff (rst)
    $rose(pins_reg.write_n) |-> low_cnt_reg >= CNT_W'(WR_CYC))
    else $error("write pulse too short");

  a_hold_after_stall: assert property (
    @(posedge clk) disable iff (rst)
    $rose(pins_reg.write_n) |-> $past(stall_s) && $past(stall_s, 2))
    else $error("strobe released too soon after stall");

  a_strobe_in_select: assert property (
    @(posedge clk) disable iff (rst)
    !pins_reg.write_n |-> !pins_reg.select_n && $past(!pins_reg.select_n))
    else $error("strobe low without earlier select");

  a_done_after_release: assert property (
    @(posedge clk) disable iff (rst)
    $rose(pins_reg.select_n) |-> s_access_close)
    else $error("access end not answered");

endmodule
`default_nettype wire

// >>> tb/dpm_mem_model.sv
// Behavioural model of one memory port with stall and mailbox
`default_nettype none
module dpm_mem_model
  import dpm_pkg::*;
(
  // Port pins
  input wire dpm_pins_t pins,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  output logic [DATA_W-1:0] data_in,
  output logic stall_n,
  output logic mailbox_flag_n,
  // Far port stand-in
  input wire logic peer_busy,
  input wire logic peer_mbox_set,
  output logic peer_flag_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [0:1023];
  logic [DATA_W-1:0] last;
  logic sel;
  logic wr;
  logic rd;
  logic clr;
  assign sel = !pins.select_n;
  assign stall_n = !(sel && peer_busy);
  assign wr = sel && !pins.write_n && stall_n;
  assign rd = sel && pins.write_n && !pins.out_en_n;
  // stalled reads show the inverse
  // Released pins show the inverse so stale data never looks valid
  assign data_in = (rd && stall_n) ? mem[pins.addr] : ~last;
  // Own flag clears on select and enable, strobe level ignored
  assign clr = sel && !pins.out_en_n && pins.addr == LEFT_MAILBOX_ADDR;
  initial
  begin
    last = 8'h00;
    mailbox_flag_n = 1'b1;
    peer_flag_n = 1'b1;
  end
  // store at write end unless stalled; undriven data is stored inverted
  always @(negedge wr)
  begin
    if (stall_n)
    begin
      mem[pins.addr] = data_oe ? data_out : ~data_out;
      // right flag on write of 3FF, at once
      if (pins.addr == RIGHT_MAILBOX_ADDR)
        peer_flag_n = 1'b0;
    end
  end
  always @(negedge rd)
    last = mem[pins.addr];
  // left flag set by peer, cleared by read
  always @(posedge peer_mbox_set or posedge clr)
    mailbox_flag_n = clr;
endmodule
`default_nettype wire

// >>> tb/dpm_port_ctrl_test.sv
// Self-checking bench for the memory port controller
`default_nettype none
module dpm_port_ctrl_test
  import dpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, req_valid, req_ready, done, was_stalled;
  logic mailbox_pending, data_oe, stall_n, mailbox_flag_n;
  logic peer_busy, peer_mbox_set, peer_flag_n;
  logic [DATA_W-1:0] rdata, data_in, data_out;
  dpm_req_t req;
  dpm_pins_t pins;
  int errors, n_tests;
  dpm_port_ctrl dut_u (.clk, .rst, .req_valid, .req_ready, .req, .done,
    .rdata, .was_stalled, .mailbox_pending, .pins, .data_in, .data_out,
    .data_oe, .stall_n, .mailbox_flag_n);
  dpm_mem_model m_u (.pins, .data_out, .data_oe, .data_in, .stall_n,
    .mailbox_flag_n, .peer_busy, .peer_mbox_set, .peer_flag_n);
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Returns at the falling edge inside the done cycle
  task automatic access(logic w, logic [9:0] a, logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= {w, a, d};
    @(posedge clk);
    req_valid <= 1'b0;
    do
      @(negedge clk);
    while (done !== 1'b1 && ++i < 60);
    if (i == 60)
    begin
      errors++;
      summarize();
    end
  endtask
  task automatic t_reset();
    chk("select_n", 8'h01, pins.select_n);
    chk("write_n", 8'h01, pins.write_n);
    chk("data_oe", 8'h00, data_oe);
    chk("req_ready", 8'h01, req_ready);
  endtask
  task automatic t_rw();
    logic [9:0] a [3] = '{10'h000, 10'h155, 10'h3FD};
    logic [7:0] d [3] = '{8'h5A, 8'hC3, 8'hFF};
    foreach (a[k])
      access(1'b1, a[k], d[k]);
    foreach (a[k])
    begin
      access(1'b0, a[k], 8'h00);
      chk("rdata", d[k], rdata);
      chk("was_stalled", 8'h00, was_stalled);
    end
  endtask
  task automatic t_stall();
    access(1'b1, 10'h100, 8'h11);
    @(posedge clk) peer_busy <= 1'b1;
    fork
      access(1'b1, 10'h100, 8'h22);
      begin
        repeat (8) @(negedge clk);
        chk("mem_stalled", 8'h11, m_u.mem[10'h100]);
        @(posedge clk) peer_busy <= 1'b0;
      end
    join
    chk("was_stalled", 8'h01, was_stalled);
    @(posedge clk) peer_busy <= 1'b1;
    fork
      access(1'b0, 10'h100, 8'h00);
      begin
        repeat (8) @(negedge clk);
        @(posedge clk) peer_busy <= 1'b0;
      end
    join
    chk("rdata_resumed", 8'h22, rdata);
    chk("read_stalled", 8'h01, was_stalled);
  endtask
  task automatic t_mbox();
    @(posedge clk) peer_mbox_set <= 1'b1;
    @(posedge clk) peer_mbox_set <= 1'b0;
    repeat (5) @(negedge clk);
    chk("pending_set", 8'h01, mailbox_pending);
    access(1'b0, LEFT_MAILBOX_ADDR, 8'h00);
    repeat (5) @(negedge clk);
    chk("pending_clr", 8'h00, mailbox_pending);
    chk("peer_flag_idle", 8'h01, peer_flag_n);
    access(1'b1, RIGHT_MAILBOX_ADDR, 8'h77);
    chk("peer_flag_n", 8'h00, peer_flag_n);
    access(1'b0, RIGHT_MAILBOX_ADDR, 8'h00);
    chk("rdata_3ff", 8'h77, rdata);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    peer_busy = 1'b0;
    peer_mbox_set = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_rw();
    t_stall();
    t_mbox();
    summarize();
  end
endmodule
`default_nettype wire
